// file: sim/wma_mac_chk.sv
`timescale 1ns/100ps
`default_nettype none
module wma_mac_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Watched inputs
	input wire logic [15:0] cfg_sifs_cyc,
	input wire logic [15:0] cfg_sifs_tol_cyc,
	input wire logic [15:0] cfg_slot_base_cyc,
	input wire logic [15:0] cfg_turnaround_cyc,
	input wire logic [15:0] cfg_ack_timeout_cyc,
	input wire logic rx_end,
	input wire logic rx_retry,
	input wire logic tx_end,
	input wire logic tx_wants_ack,
	input wire logic tx_new_msdu,
	// Watched outputs
	input wire logic ack_start,
	input wire logic rx_deliver,
	input wire logic rx_dup_drop,
	input wire logic tx_fail,
	input wire logic tx_ack_ok,
	input wire logic [11:0] tx_seq,
	input wire logic [15:0] tx_sifs_bnd,
	input wire logic [15:0] tx_pifs_bnd,
	input wire logic [15:0] tx_difs_bnd,
	input wire logic [15:0] pifs_cyc,
	input wire logic [15:0] difs_cyc,
	input wire logic cfp_active,
	input wire logic beacon_start,
	input wire logic beacon_dtim
);
	logic [15:0] rx_cnt_reg, rx_cnt_next, to_cnt_reg, to_cnt_next, slot;
	logic to_wait_reg, to_wait_next;
	assign slot = cfg_slot_base_cyc + 16'h00C8;
	// Cycles since last received frame end, and time spent waiting for an ack
	always_comb begin
		rx_cnt_next = rx_end ? 16'h0000 : rx_cnt_reg + {15'h0000, rx_cnt_reg != 16'hFFFF};
		to_wait_next = (to_wait_reg || (tx_end && tx_wants_ack)) && !tx_fail && !tx_ack_ok;
		to_cnt_next = to_wait_reg ? to_cnt_reg + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_cnt_reg <= 16'hFFFF;
			to_wait_reg <= 1'b0;
			to_cnt_reg <= 16'h0000;
		end else begin
			rx_cnt_reg <= rx_cnt_next;
			to_wait_reg <= to_wait_next;
			to_cnt_reg <= to_cnt_next;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_ack_spacing: assert property (ack_start |-> rx_cnt_reg == cfg_sifs_cyc + cfg_sifs_tol_cyc)
		else $error("ack start off its spacing");
	a_seq_step: assert property (tx_new_msdu |=> tx_seq == $past(tx_seq) + 12'h001)
		else $error("sequence did not step");
	a_seq_hold: assert property (!tx_new_msdu |=> $stable(tx_seq))
		else $error("sequence moved without new unit");
	a_ifs_sums: assert property (!$past(reset) |-> pifs_cyc == $past(cfg_sifs_cyc + slot)
		&& difs_cyc == $past(cfg_sifs_cyc + 16'(2 * slot))) else $error("spacing sums wrong");
	a_tx_bounds: assert property (!$past(reset) |-> tx_sifs_bnd == $past(cfg_sifs_cyc - cfg_turnaround_cyc)
		&& tx_pifs_bnd == $past(cfg_sifs_cyc - cfg_turnaround_cyc + slot)
		&& tx_difs_bnd == $past(cfg_sifs_cyc - cfg_turnaround_cyc + 16'(2 * slot)))
		else $error("slot boundaries wrong");
	a_dup_cause: assert property (rx_dup_drop |-> $past(rx_end && rx_retry) && !rx_deliver)
		else $error("drop without retried frame");
	a_deliver_cause: assert property (rx_deliver |-> $past(rx_end))
		else $error("delivery without frame");
	a_fail_late: assert property (tx_fail |-> to_wait_reg && to_cnt_reg >= cfg_ack_timeout_cyc)
		else $error("failure before timeout");
	a_fail_bound: assert property (to_wait_reg |-> to_cnt_reg <= cfg_ack_timeout_cyc + 16'h0008)
		else $error("failure overdue");
	a_cfp_start: assert property ($rose(cfp_active) |-> $past(beacon_start && beacon_dtim)
		|| (beacon_start && beacon_dtim)) else $error("period began without indication beacon");
endmodule : wma_mac_chk
bind wma_mac wma_mac_chk u_chk (.mclk, .reset, .cfg_sifs_cyc, .cfg_sifs_tol_cyc, .cfg_slot_base_cyc,
	.cfg_turnaround_cyc, .cfg_ack_timeout_cyc, .rx_end, .rx_retry, .tx_end, .tx_wants_ack,
	.tx_new_msdu, .ack_start, .rx_deliver, .rx_dup_drop, .tx_fail, .tx_ack_ok, .tx_seq,
	.tx_sifs_bnd, .tx_pifs_bnd, .tx_difs_bnd, .pifs_cyc, .difs_cyc, .cfp_active,
	.beacon_start, .beacon_dtim);
`default_nettype wire

// file: sim/wma_mac_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module wma_mac_tb_top;
	localparam int SIFS = 20, TOL = 3, TURN = 4, TMO = 60;
	localparam int SLOT = 10 + wma_pkg::MEDIUM_DELAY_CYC;
	logic mclk, reset = 1'b1, cfg_is_ap = 1'b0, cfg_cf_capable = 1'b1, tx_end = 1'b0;
	logic tx_wants_ack = 1'b0, tx_new_msdu = 1'b0, tbtt = 1'b0, poll_frame_ready = 1'b1;
	logic [15:0] cfg_sifs_cyc = 16'(SIFS), cfg_sifs_tol_cyc = 16'(TOL), cfg_slot_base_cyc = 16'h000A;
	logic [15:0] cfg_turnaround_cyc = 16'(TURN), cfg_ack_timeout_cyc = 16'(TMO);
	logic [15:0] cfg_cfp_max_ms = 16'h0000;
	logic [7:0] cfg_cfp_rate = 8'h01, cfg_dtim_period = 8'h01;
	wire logic rx_end, rx_fcs_ok, rx_is_data, rx_is_mgmt, rx_is_ack, rx_to_ap, rx_group;
	wire logic rx_for_us, rx_retry, rx_poll;
	wire logic [8:0] rx_flags;
	wire logic [47:0] rx_src;
	wire logic [11:0] rx_seq;
	wire logic [3:0] rx_frag;
	logic ack_start, rx_deliver, rx_dup_drop, tx_fail, tx_ack_ok, poll_tx_start, pcf_active;
	logic cfp_active, beacon_dtim, beacon_start, cf_end_send;
	logic [11:0] tx_seq;
	logic [15:0] tx_sifs_bnd, tx_pifs_bnd, tx_difs_bnd, pifs_cyc, difs_cyc, beacon_dur_ms;
	logic [1:0] ifs_elapsed;
	logic [37:0] notes[$];
	logic [37:0] n;
	logic [31:0] cyc = 32'h0;
	logic [5:0] ev;
	logic [47:0] sa[5];
	logic [17:0] r;
	logic [15:0] seed;
	int fail_count = 0, num_checks = 0;
	assign {rx_fcs_ok, rx_is_data, rx_is_mgmt, rx_is_ack, rx_to_ap, rx_group, rx_for_us,
		rx_retry, rx_poll} = rx_flags;
	wma_peer u_peer (.mclk, .tx_end, .tx_wants_ack, .rx_end, .rx_flags, .rx_src, .rx_seq, .rx_frag);
	wma_mac u_dut (.mclk, .reset, .cfg_is_ap, .cfg_cf_capable, .cfg_sifs_cyc, .cfg_sifs_tol_cyc,
		.cfg_slot_base_cyc, .cfg_turnaround_cyc, .cfg_ack_timeout_cyc, .cfg_cfp_max_ms,
		.cfg_cfp_rate, .cfg_dtim_period, .rx_end, .rx_fcs_ok, .rx_is_data, .rx_is_mgmt,
		.rx_is_ack, .rx_to_ap, .rx_group, .rx_for_us, .rx_retry, .rx_poll, .rx_src, .rx_seq,
		.rx_frag, .tx_end, .tx_wants_ack, .tx_new_msdu, .tbtt, .poll_frame_ready, .ack_start,
		.rx_deliver, .rx_dup_drop, .tx_fail, .tx_ack_ok, .tx_seq, .tx_sifs_bnd, .tx_pifs_bnd,
		.tx_difs_bnd, .pifs_cyc, .difs_cyc, .ifs_elapsed, .poll_tx_start, .pcf_active,
		.cfp_active, .beacon_dtim, .beacon_start, .beacon_dur_ms, .cf_end_send);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic drain();
		for (int i = 0; i < 400 && notes.size() > 0; i++) @(negedge mclk);
		if (notes.size() > 0) begin
			fail_count++;
			finish_test();
		end
	endtask : drain
	// Send one frame, noting the delivery code and the ack code due at its exact cycle
	task automatic frm(input logic [8:0] f, input logic [47:0] s, input logic [3:0] g,
		input logic [5:0] d, input logic [5:0] a);
		if (d != 6'h00) notes.push_back({32'h0, d});
		if (a != 6'h00) notes.push_back({cyc + 32'(SIFS + TOL + 1), a});
		u_peer.send(f, s, s[11:0], g);
		drain();
	endtask : frm
	task automatic txf(input int d, input logic [5:0] e);
		u_peer.ack_dly = d;
		notes.push_back({32'h0, e});
		tx_end = 1'b1;
		tx_wants_ack = 1'b1;
		@(negedge mclk);
		tx_end = 1'b0;
		drain();
	endtask : txf
	task automatic bcn();
		tbtt = 1'b1;
		@(negedge mclk);
		tbtt = 1'b0;
		r = {beacon_start, beacon_dtim, beacon_dur_ms};
	endtask : bcn
	// Every cycle with a result pulse takes the oldest note
	always @(posedge mclk) begin
		ev = {poll_tx_start, ack_start, rx_deliver, rx_dup_drop, tx_fail, tx_ack_ok};
		if (reset === 1'b0 && ev !== 6'h00) begin
			n = (notes.size() > 0) ? notes.pop_front() : 38'h0;
			`CHK(ev, n[5:0])
			if (n[37:6] != 32'h0) `CHK(cyc, n[37:6])
		end
		cyc <= cyc + 32'h1;
	end
	initial begin
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(tx_seq, 12'h000)
		`CHK(pifs_cyc, 16'(SIFS + SLOT))
		`CHK(difs_cyc, 16'(SIFS + 2 * SLOT))
		`CHK(tx_sifs_bnd, 16'(SIFS - TURN))
		`CHK(tx_pifs_bnd, 16'(SIFS - TURN + SLOT))
		`CHK(tx_difs_bnd, 16'(SIFS - TURN + 2 * SLOT))
		for (int k = 0; k < 3; k++) begin
			tx_new_msdu = 1'b1;
			@(negedge mclk);
			tx_new_msdu = 1'b0;
			@(negedge mclk);
		end
		`CHK(tx_seq, 12'h003)
		seed = 16'h4052;
		for (int k = 0; k < 5; k++) begin
			seed = lfsr(seed);
			sa[k] = {32'h0, seed};
			frm(9'h184, sa[k], 4'h0, 6'h08, 6'h10);
		end
		frm(9'h186, sa[4], 4'h1, 6'h08, 6'h10);
		frm(9'h186, sa[0], 4'h0, 6'h08, 6'h10);
		frm(9'h186, sa[3], 4'h0, 6'h04, 6'h10);
		frm(9'h184, sa[3], 4'h0, 6'h08, 6'h10);
		frm(9'h18C, sa[1], 4'h0, 6'h08, 6'h00);
		frm(9'h185, sa[2], 4'h2, 6'h08, 6'h30);
		cfg_is_ap = 1'b1;
		frm(9'h198, sa[1], 4'h3, 6'h00, 6'h10);
		u_peer.send(9'h120, 48'h0, 12'h000, 4'h0);
		repeat (2) @(negedge mclk);
		`CHK(ifs_elapsed, 2'h0)
		repeat (SIFS + SLOT) @(negedge mclk);
		`CHK(ifs_elapsed, 2'h1)
		repeat (SLOT) @(negedge mclk);
		`CHK(ifs_elapsed, 2'h3)
		txf(5, 6'h01);
		txf(40, 6'h01);
		txf(0, 6'h02);
		cfg_cfp_max_ms = 16'h0003;
		repeat (2) @(negedge mclk);
		`CHK(pcf_active, 1'b1)
		bcn();
		`CHK(r, {2'b11, 16'h0003})
		@(negedge mclk);
		`CHK(cfp_active, 1'b1)
		bcn();
		`CHK(r[15:0] !== 16'h0000, 1'b1)
		cfg_cfp_max_ms = 16'h0000;
		for (int i = 0; i < 20 && cf_end_send !== 1'b1; i++) @(negedge mclk);
		`CHK(cf_end_send, 1'b1)
		repeat (2) @(negedge mclk);
		`CHK({cfp_active, pcf_active}, 2'b00)
		bcn();
		`CHK(r, {2'b10, 16'h0000})
		finish_test();
	end
endmodule : wma_mac_tb_top
`default_nettype wire

// file: sim/wma_peer.sv
`timescale 1ns/100ps
`default_nettype none
module wma_peer (
	// Clock
	input wire logic mclk,
	// Own transmissions
	input wire logic tx_end,
	input wire logic tx_wants_ack,
	// Frames on the medium
	output logic rx_end,
	output logic [8:0] rx_flags,
	output logic [47:0] rx_src,
	output logic [11:0] rx_seq,
	output logic [3:0] rx_frag
);
	int ack_dly = 0;
	initial begin
		rx_end = 1'b0;
		rx_flags = 9'h000;
		rx_src = 48'h0;
		rx_seq = 12'h000;
		rx_frag = 4'h0;
	end
	// Frame end pulse; qualifiers invert once released
	task automatic send(input logic [8:0] f, input logic [47:0] s, input logic [11:0] q,
		input logic [3:0] g);
		rx_end = 1'b1;
		rx_flags = f;
		rx_src = s;
		rx_seq = q;
		rx_frag = g;
		@(negedge mclk);
		rx_end = 1'b0;
		rx_flags = ~f;
		rx_src = ~s;
		rx_seq = ~q;
		rx_frag = ~g;
	endtask : send
	// Answer a frame needing ack after a chosen delay, or stay silent
	always @(posedge mclk) begin
		if (tx_end === 1'b1 && tx_wants_ack === 1'b1 && ack_dly > 0) begin
			repeat (ack_dly) @(negedge mclk);
			send(9'h120, 48'h0, 12'h000, 4'h0);
		end
	end
endmodule : wma_peer
`default_nettype wire

// file: src/wma_cache_entry.sv
`timescale 1ns/100ps
`default_nettype none
// One duplicate cache entry: stores a tuple and reports a match
module wma_cache_entry (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Write port
	input wire logic wr,
	input wire logic [wma_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [wma_pkg::SEQ_W-1:0] wr_seq,
	input wire logic [wma_pkg::FRAG_W-1:0] wr_frag,
	// Compare port
	input wire logic [wma_pkg::ADDR_W-1:0] cmp_addr,
	input wire logic [wma_pkg::SEQ_W-1:0] cmp_seq,
	input wire logic [wma_pkg::FRAG_W-1:0] cmp_frag,
	output logic hit
);
	logic valid_reg, valid_next;
	logic [wma_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [wma_pkg::SEQ_W-1:0] seq_reg, seq_next;
	logic [wma_pkg::FRAG_W-1:0] frag_reg, frag_next;

	always_comb begin
		valid_next = valid_reg | wr;
		addr_next = wr ? wr_addr : addr_reg;
		seq_next = wr ? wr_seq : seq_reg;
		frag_next = wr ? wr_frag : frag_reg;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			valid_reg <= 1'b0;
			addr_reg <= '0;
			seq_reg <= '0;
			frag_reg <= '0;
		end else begin
			valid_reg <= valid_next;
			addr_reg <= addr_next;
			seq_reg <= seq_next;
			frag_reg <= frag_next;
		end
	end

	assign hit = valid_reg && addr_reg == cmp_addr && seq_reg == cmp_seq && frag_reg == cmp_frag;
endmodule : wma_cache_entry
`default_nettype wire

// file: src/wma_mac.sv
`timescale 1ns/100ps
`default_nettype none
module wma_mac (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Configuration
	input wire logic cfg_is_ap,
	input wire logic cfg_cf_capable,
	input wire logic [wma_pkg::TW-1:0] cfg_sifs_cyc,
	input wire logic [wma_pkg::TW-1:0] cfg_sifs_tol_cyc,
	input wire logic [wma_pkg::TW-1:0] cfg_slot_base_cyc,
	input wire logic [wma_pkg::TW-1:0] cfg_turnaround_cyc,
	input wire logic [wma_pkg::TW-1:0] cfg_ack_timeout_cyc,
	input wire logic [wma_pkg::MSW-1:0] cfg_cfp_max_ms,
	input wire logic [7:0] cfg_cfp_rate,
	input wire logic [7:0] cfg_dtim_period,
	// Medium events
	input wire logic rx_end,
	input wire logic rx_fcs_ok,
	input wire logic rx_is_data,
	input wire logic rx_is_mgmt,
	input wire logic rx_is_ack,
	input wire logic rx_to_ap,
	input wire logic rx_group,
	input wire logic rx_for_us,
	input wire logic rx_retry,
	input wire logic rx_poll,
	input wire logic [wma_pkg::ADDR_W-1:0] rx_src,
	input wire logic [wma_pkg::SEQ_W-1:0] rx_seq,
	input wire logic [wma_pkg::FRAG_W-1:0] rx_frag,
	input wire logic tx_end,
	input wire logic tx_wants_ack,
	// Upper layer requests
	input wire logic tx_new_msdu,
	input wire logic tbtt,
	input wire logic poll_frame_ready,
	// Outputs
	output logic ack_start,
	output logic rx_deliver,
	output logic rx_dup_drop,
	output logic tx_fail,
	output logic tx_ack_ok,
	output logic [wma_pkg::SEQ_W-1:0] tx_seq,
	output logic [wma_pkg::TW-1:0] tx_sifs_bnd,
	output logic [wma_pkg::TW-1:0] tx_pifs_bnd,
	output logic [wma_pkg::TW-1:0] tx_difs_bnd,
	output logic [wma_pkg::TW-1:0] pifs_cyc,
	output logic [wma_pkg::TW-1:0] difs_cyc,
	output logic [1:0] ifs_elapsed,
	output logic poll_tx_start,
	output logic pcf_active,
	output logic cfp_active,
	output logic beacon_dtim,
	output logic beacon_start,
	output logic [wma_pkg::MSW-1:0] beacon_dur_ms,
	output logic cf_end_send
);
	// Derived timings
	logic [wma_pkg::TW-1:0] slot, sifs_tol, sifs_bnd;
	logic [wma_pkg::TW-1:0] pifs_reg, pifs_next, difs_reg, difs_next;
	logic [wma_pkg::TW-1:0] bs_reg, bs_next, bp_reg, bp_next, bd_reg, bd_next;

	always_comb begin
		slot = cfg_slot_base_cyc + wma_pkg::TW'(wma_pkg::MEDIUM_DELAY_CYC);
		sifs_tol = cfg_sifs_cyc + cfg_sifs_tol_cyc;
		sifs_bnd = cfg_sifs_cyc - cfg_turnaround_cyc;
		pifs_next = cfg_sifs_cyc + slot;
		difs_next = cfg_sifs_cyc + {slot[wma_pkg::TW-2:0], 1'b0};
		bs_next = sifs_bnd;
		bp_next = sifs_bnd + slot;
		bd_next = sifs_bnd + {slot[wma_pkg::TW-2:0], 1'b0};
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pifs_reg <= wma_pkg::TIME_ZERO;
			difs_reg <= wma_pkg::TIME_ZERO;
			bs_reg <= wma_pkg::TIME_ZERO;
			bp_reg <= wma_pkg::TIME_ZERO;
			bd_reg <= wma_pkg::TIME_ZERO;
		end else begin
			pifs_reg <= pifs_next;
			difs_reg <= difs_next;
			bs_reg <= bs_next;
			bp_reg <= bp_next;
			bd_reg <= bd_next;
		end
	end

	assign pifs_cyc = pifs_reg;
	assign difs_cyc = difs_reg;
	assign tx_sifs_bnd = bs_reg;
	assign tx_pifs_bnd = bp_reg;
	assign tx_difs_bnd = bd_reg;

	// Medium idle timer from the last symbol of any frame
	logic [wma_pkg::TW-1:0] idle_reg, idle_next;
	logic [1:0] ifs_reg, ifs_next;
	logic frame_end;

	always_comb begin
		frame_end = rx_end | tx_end;
		if (frame_end) begin
			idle_next = wma_pkg::TIME_ZERO;
		end else if (idle_reg != {wma_pkg::TW{1'b1}}) begin
			idle_next = idle_reg + 16'h0001;
		end else begin
			idle_next = idle_reg;
		end
		ifs_next = {idle_next >= difs_reg, idle_next >= pifs_reg};
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			idle_reg <= wma_pkg::TIME_ZERO;
			ifs_reg <= 2'h0;
		end else begin
			idle_reg <= idle_next;
			ifs_reg <= ifs_next;
		end
	end

	assign ifs_elapsed = ifs_reg;

	// Duplicate cache
	logic [wma_pkg::CACHE_DEPTH-1:0] hits, wr_sel;
	logic [wma_pkg::CACHE_IW-1:0] victim_reg, victim_next;
	logic good, want_ack, is_dup, cache_wr;

	genvar gi;
	generate
		for (gi = 0; gi < wma_pkg::CACHE_DEPTH; gi++) begin : g_cache
			wma_cache_entry u_entry (
				.mclk(mclk),
				.reset(reset),
				.wr(wr_sel[gi]),
				.wr_addr(rx_src),
				.wr_seq(rx_seq),
				.wr_frag(rx_frag),
				.cmp_addr(rx_src),
				.cmp_seq(rx_seq),
				.cmp_frag(rx_frag),
				.hit(hits[gi])
			);
		end
	endgenerate

	always_comb begin
		good = rx_end && rx_fcs_ok && (rx_is_data || rx_is_mgmt);
		want_ack = good && ((cfg_is_ap && rx_to_ap) ||
			(rx_for_us && !(rx_group && rx_is_data)));
		is_dup = rx_retry && (hits != '0);
		cache_wr = good && rx_for_us && !is_dup && !rx_group;
		wr_sel = '0;
		if (cache_wr) begin
			wr_sel[victim_reg] = 1'b1;
		end
		victim_next = cache_wr ? victim_reg + 2'h1 : victim_reg;
	end

	// Acknowledgement generator
	wma_pkg::wma_ack_e ak_reg, ak_next;
	logic [wma_pkg::TW-1:0] akc_reg, akc_next;
	logic ack_start_reg, ack_start_next, deliver_reg, deliver_next, drop_reg, drop_next;

	always_comb begin
		ak_next = ak_reg;
		akc_next = akc_reg;
		ack_start_next = 1'b0;
		deliver_next = good && rx_for_us && !is_dup;
		drop_next = good && is_dup;
		case (ak_reg)
			wma_pkg::AK_IDLE: begin
				if (want_ack) begin
					ak_next = wma_pkg::AK_WAIT;
					akc_next = 16'h0001;
				end
			end
			wma_pkg::AK_WAIT: begin
				// Counter holds cycles since frame end; the start flop lands on the spacing edge
				if (akc_reg >= sifs_tol) begin
					ak_next = wma_pkg::AK_SEND;
					ack_start_next = 1'b1;
				end else begin
					akc_next = akc_reg + 16'h0001;
				end
			end
			wma_pkg::AK_SEND: ak_next = wma_pkg::AK_IDLE;
			default: ak_next = wma_pkg::AK_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ak_reg <= wma_pkg::AK_IDLE;
			akc_reg <= wma_pkg::TIME_ZERO;
			ack_start_reg <= 1'b0;
			deliver_reg <= 1'b0;
			drop_reg <= 1'b0;
			victim_reg <= '0;
		end else begin
			ak_reg <= ak_next;
			akc_reg <= akc_next;
			ack_start_reg <= ack_start_next;
			deliver_reg <= deliver_next;
			drop_reg <= drop_next;
			victim_reg <= victim_next;
		end
	end

	assign ack_start = ack_start_reg;
	assign rx_deliver = deliver_reg;
	assign rx_dup_drop = drop_reg;

	// Acknowledgement timeout and sequence numbering
	wma_pkg::wma_to_e to_reg, to_next;
	logic [wma_pkg::TW-1:0] toc_reg, toc_next;
	logic fail_reg, fail_next, ok_reg, ok_next;
	logic [wma_pkg::SEQ_W-1:0] seq_reg, seq_next;

	always_comb begin
		to_next = to_reg;
		toc_next = toc_reg;
		fail_next = 1'b0;
		ok_next = 1'b0;
		// Fragments keep the number; only a new MSDU advances it
		seq_next = tx_new_msdu ? seq_reg + 12'h001 : seq_reg;
		case (to_reg)
			wma_pkg::TO_IDLE: begin
				if (tx_end && tx_wants_ack) begin
					to_next = wma_pkg::TO_WAIT;
					toc_next = 16'h0001;
				end
			end
			wma_pkg::TO_WAIT: begin
				if (rx_end && rx_fcs_ok && rx_is_ack) begin
					ok_next = 1'b1;
					to_next = wma_pkg::TO_IDLE;
				end else if (toc_reg >= cfg_ack_timeout_cyc) begin
					fail_next = 1'b1;
					to_next = wma_pkg::TO_FAIL;
				end else begin
					toc_next = toc_reg + 16'h0001;
				end
			end
			wma_pkg::TO_FAIL: to_next = wma_pkg::TO_IDLE;
			default: to_next = wma_pkg::TO_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			to_reg <= wma_pkg::TO_IDLE;
			toc_reg <= wma_pkg::TIME_ZERO;
			fail_reg <= 1'b0;
			ok_reg <= 1'b0;
			seq_reg <= wma_pkg::SEQ_RESET;
		end else begin
			to_reg <= to_next;
			toc_reg <= toc_next;
			fail_reg <= fail_next;
			ok_reg <= ok_next;
			seq_reg <= seq_next;
		end
	end

	assign tx_fail = fail_reg;
	assign tx_ack_ok = ok_reg;
	assign tx_seq = seq_reg;

	// Polled response: one frame per poll
	logic polled_reg, polled_next, poll_tx_reg, poll_tx_next;

	always_comb begin
		polled_next = polled_reg;
		poll_tx_next = 1'b0;
		if (good && rx_for_us && rx_poll && cfg_cf_capable) begin
			polled_next = 1'b1;
		end else if (polled_reg && ack_start_next) begin
			// Frame goes out in the acknowledgement slot, carrying it
			poll_tx_next = poll_frame_ready;
			polled_next = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			polled_reg <= 1'b0;
			poll_tx_reg <= 1'b0;
		end else begin
			polled_reg <= polled_next;
			poll_tx_reg <= poll_tx_next;
		end
	end

	assign poll_tx_start = poll_tx_reg;

	// Contention-free period skeleton at the coordinator
	wma_pkg::wma_cf_e cf_reg, cf_next;
	logic [7:0] bcnt_reg, bcnt_next, per_beacons;
	logic [wma_pkg::CW-1:0] mscyc_reg, mscyc_next;
	logic [wma_pkg::MSW-1:0] left_reg, left_next;
	logic pcf_on, bstart_next, bstart_reg, dtim_next, dtim_reg, end_next, end_reg;
	logic [wma_pkg::MSW-1:0] bdur_next, bdur_reg;

	always_comb begin
		pcf_on = cfg_is_ap && (cfg_cfp_max_ms != 16'h0000);
		per_beacons = 8'(cfg_cfp_rate * cfg_dtim_period);
		cf_next = cf_reg;
		bcnt_next = bcnt_reg;
		mscyc_next = mscyc_reg;
		left_next = left_reg;
		bstart_next = 1'b0;
		dtim_next = 1'b0;
		end_next = 1'b0;
		bdur_next = bdur_reg;
		if (tbtt) begin
			bstart_next = 1'b1;
			bcnt_next = (bcnt_reg + 8'h01 >= per_beacons) ? 8'h00 : bcnt_reg + 8'h01;
		end
		case (cf_reg)
			wma_pkg::CF_CP: begin
				if (tbtt) begin
					bdur_next = 16'h0000;
				end
				if (tbtt && pcf_on && bcnt_reg == 8'h00) begin
					cf_next = wma_pkg::CF_CFP;
					dtim_next = 1'b1;
					left_next = cfg_cfp_max_ms;
					bdur_next = cfg_cfp_max_ms;
					mscyc_next = '0;
				end
			end
			wma_pkg::CF_CFP: begin
				if (mscyc_reg == wma_pkg::CW'(wma_pkg::MS_CYC - 1)) begin
					mscyc_next = '0;
					left_next = left_reg - 16'h0001;
				end else begin
					mscyc_next = mscyc_reg + 20'h00001;
				end
				if (tbtt) begin
					bdur_next = left_reg;
				end
				if (left_reg == 16'h0000 || !pcf_on) begin
					cf_next = wma_pkg::CF_END;
				end
			end
			wma_pkg::CF_END: begin
				end_next = 1'b1;
				cf_next = wma_pkg::CF_CP;
			end
			default: cf_next = wma_pkg::CF_CP;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cf_reg <= wma_pkg::CF_CP;
			bcnt_reg <= 8'h00;
			mscyc_reg <= '0;
			left_reg <= 16'h0000;
			bstart_reg <= 1'b0;
			dtim_reg <= 1'b0;
			end_reg <= 1'b0;
			bdur_reg <= 16'h0000;
		end else begin
			cf_reg <= cf_next;
			bcnt_reg <= bcnt_next;
			mscyc_reg <= mscyc_next;
			left_reg <= left_next;
			bstart_reg <= bstart_next;
			dtim_reg <= dtim_next;
			end_reg <= end_next;
			bdur_reg <= bdur_next;
		end
	end

	// Coordinator status as flops
	logic pcf_reg, cfpa_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pcf_reg <= 1'b0;
			cfpa_reg <= 1'b0;
		end else begin
			pcf_reg <= pcf_on;
			cfpa_reg <= (cf_next == wma_pkg::CF_CFP);
		end
	end

	assign pcf_active = pcf_reg;
	assign cfp_active = cfpa_reg;
	assign beacon_start = bstart_reg;
	assign beacon_dtim = dtim_reg;
	assign beacon_dur_ms = bdur_reg;
	assign cf_end_send = end_reg;
endmodule : wma_mac
`default_nettype wire

// file: src/wma_pkg.sv
package wma_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 5;
	// Medium propagation component of the slot time
	localparam int MEDIUM_DELAY_US = 1;
	localparam int MEDIUM_DELAY_CYC = (MEDIUM_DELAY_US * 1000) / CLK_PERIOD_NS;
	// Timing field widths, all spacing values in clock cycles
	localparam int TW = 16;
	localparam int CW = 20;
	// Duplicate cache
	localparam int CACHE_DEPTH = 4;
	localparam int CACHE_IW = 2;
	localparam int ADDR_W = 48;
	localparam int SEQ_W = 12;
	localparam int FRAG_W = 4;
	// Remaining-duration in milliseconds
	localparam int MS_CYC = 1000000 / CLK_PERIOD_NS;
	localparam int MSW = 16;
	// Reset values
	localparam logic [SEQ_W-1:0] SEQ_RESET = 12'h000;
	localparam logic [TW-1:0] TIME_ZERO = 16'h0000;
	// Boundary select encodings
	localparam logic [1:0] BND_SIFS = 2'h0;
	localparam logic [1:0] BND_PIFS = 2'h1;
	localparam logic [1:0] BND_DIFS = 2'h2;

	typedef enum logic [1:0] {
		AK_IDLE = 2'b00,
		AK_WAIT = 2'b01,
		AK_SEND = 2'b11
	} wma_ack_e;

	typedef enum logic [1:0] {
		TO_IDLE = 2'b00,
		TO_WAIT = 2'b01,
		TO_FAIL = 2'b11
	} wma_to_e;

	typedef enum logic [1:0] {
		CF_CP = 2'b00,
		CF_CFP = 2'b01,
		CF_END = 2'b11
	} wma_cf_e;
endpackage : wma_pkg
